// ===== logic/dioth_cfg.svh
// constants for the digital i/o timing and handshake engine
`ifndef DIOTH_CFG_SVH
`define DIOTH_CFG_SVH
// register offsets (byte addresses)
`define DIOTH_REG_CTRL     8'h00
`define DIOTH_REG_DIV      8'h04
`define DIOTH_REG_RISE     8'h08
`define DIOTH_REG_FALL     8'h0C
`define DIOTH_REG_STATUS   8'h10
`define DIOTH_REG_DATA     8'h14
`define DIOTH_REG_OUTDATA  8'h18
`define DIOTH_REG_COUNT    8'h1C
`define DIOTH_REG_CMD      8'h20
// control field positions
`define DIOTH_CTL_EN       0
`define DIOTH_CTL_MODE_LO  1
`define DIOTH_CTL_MODE_HI  3
`define DIOTH_CTL_EXTCLK   4
`define DIOTH_CTL_FALLEDGE 5
`define DIOTH_CTL_OUTDIR   6
`define DIOTH_CTL_WID_LO   7
`define DIOTH_CTL_WID_HI   8
`define DIOTH_CTL_SINGLE   9
`define DIOTH_CTL_GRP_LO   10
`define DIOTH_CTL_GRP_HI   11
// status field positions
`define DIOTH_ST_OVF       0
`define DIOTH_ST_VALID     1
`define DIOTH_ST_LATE      2
`define DIOTH_ST_BADMODE   3
`define DIOTH_ST_BUSY      4
// reset values
`define DIOTH_DIV_RST      32'h0000_0032
`endif

// ===== logic/dioth_pkg.sv
// types for the digital i/o timing and handshake engine
package dioth_pkg;
    typedef enum logic [2:0] {
        DIOTH_SAMPCLK, DIOTH_ONDEMAND, DIOTH_CHANGE, DIOTH_HSHAKE,
        DIOTH_BURST, DIOTH_MODE_R5, DIOTH_MODE_R6, DIOTH_MODE_R7
    } dioth_mode_t;
    typedef enum logic [1:0] {
        DIOTH_IDLE, DIOTH_WAIT, DIOTH_DONE
    } dioth_hs_t;
    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dioth_bus_t;
    // handshake lines of one port pair
    typedef struct packed {
        logic input_full_flag;
        logic output_full_flag;
        logic transfer_ready;
    } dioth_hsout_t;
endpackage

// ===== logic/dioth_core.sv
// timing and handshake sampling engine for a grouped digital i/o port
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "dioth_cfg.svh"
// Operation
// R1: one sample per channel each clock tick
// R2: sample clock onboard divider or external
// R3: on-demand samples at once, quantity ignored
// R4: change capture on per-line selectable edges
// R5: unread sample at next change sets overflow
// R6: overflow readable in status any time
// R7: burst transfer needs hold low, ready high
// R8: other hold/ready combinations stall transfer
// R9: burst active edge rising or falling
// R10: peripheral strobes again before each word
// R11: word width 8, 16 or 32 bits
// R12: input strobe/full, output full/acknowledge pairs
// R13: input word taken while strobe low
// R14: input full flag high after word taken
// R15: output full flag low while word presented
// R16: peripheral acknowledges with low pulse
// R17: grouped ports use top port handshake lines
// R18: grouped inputs tie strobes, top full used
// R19: grouped outputs wire only last port
// R20: handshake ports and control lines reserved
// R21: single-point only sample clock or change
// R22: late single-point access raises warning
// R23: reset idles handshake lines, clears overflow
module dioth_core
#(
    parameter int NPORT = 4
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // register port
    input wire dioth_pkg::dioth_bus_t bus,
    output logic [31:0] rdata,
    // parallel data lines, eight per port
    input wire logic [8*NPORT-1:0] dio_in,
    output logic [8*NPORT-1:0] dio_out,
    output logic [8*NPORT-1:0] dio_oe,
    // external sample clock
    input wire logic ext_sample_clk,
    // per-port handshake lines
    input wire logic [NPORT-1:0] strobe_in,
    input wire logic [NPORT-1:0] peripheral_acknowledge,
    output logic [NPORT-1:0] input_full_flag,
    output logic [NPORT-1:0] output_full_flag,
    // burst handshake lines
    input wire logic transfer_hold,
    output logic transfer_ready,
    output logic sample_clk_out
);
    import dioth_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] div;
        logic [31:0] rise;
        logic [31:0] fall;
        logic [31:0] cnt;
        logic [31:0] data;
        logic [31:0] odata;
        logic [31:0] count;
        logic [31:0] prev;
        logic [31:0] rdata;
        logic ovf;
        logic valid;
        logic late;
        logic badmode;
        logic tick_pend;
        logic sclk;
        logic sclk_prev;
        logic ifull;
        logic ofull;
        logic rdy;
        logic oe;
        dioth_hs_t hs;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic [2*NPORT-1:0] hs_a;
        logic [2*NPORT-1:0] hs_b;
        logic [31:0] din_a;
        logic [31:0] din_b;
    } dioth_state_t;

    dioth_state_t st_q, st_d;
    dioth_mode_t mode;
    logic [1:0] grp;
    logic [1:0] wid;
    logic ext_s, hold_s, edge_hit, clk_edge, strb_lo, ack_lo;
    logic [31:0] din_s, width_mask, chg;
    logic [31:0] din_raw;

    // width mask for 8, 16 or 32 bit words
    function automatic logic [31:0] wmask(input logic [1:0] w);
        unique case (w)
            2'd0: wmask = 32'h0000_00FF;
            2'd1: wmask = 32'h0000_FFFF;
            default: wmask = 32'hFFFF_FFFF;
        endcase
    endfunction

    assign mode = dioth_mode_t'(st_q.ctrl[`DIOTH_CTL_MODE_HI:`DIOTH_CTL_MODE_LO]);
    assign grp = st_q.ctrl[`DIOTH_CTL_GRP_HI:`DIOTH_CTL_GRP_LO];
    assign wid = st_q.ctrl[`DIOTH_CTL_WID_HI:`DIOTH_CTL_WID_LO];
    assign width_mask = wmask(wid); // R11
    assign din_raw = dio_in[31:0];
    // synchronised copies, second stage only
    assign ext_s = st_q.sync_b[0];
    assign hold_s = st_q.sync_b[1];
    assign din_s = st_q.din_b & width_mask;
    // top port of the group owns the handshake lines
    assign strb_lo = ~st_q.hs_b[grp]; // R17 R18
    assign ack_lo = ~st_q.hs_b[NPORT+grp]; // R12 R16 R19
    // changed bits on selected edges
    assign chg = (din_s & ~st_q.prev & st_q.rise)
               | (~din_s & st_q.prev & st_q.fall); // R4
    assign edge_hit = st_q.sclk_prev != st_q.sclk
                    && st_q.sclk == ~st_q.ctrl[`DIOTH_CTL_FALLEDGE]; // R9

    // ****************************************
    // next state
    // ****************************************
    // one process holds sampling, handshakes and register port
    always_comb
    begin
        st_d = st_q;
        st_d.sync_a = {1'b0, transfer_hold, ext_sample_clk};
        st_d.sync_b = st_q.sync_a;
        st_d.hs_a = {peripheral_acknowledge, strobe_in};
        st_d.hs_b = st_q.hs_a;
        st_d.din_a = din_raw;
        st_d.din_b = st_q.din_a;
        st_d.prev = din_s;
        st_d.sclk_prev = st_q.sclk;
        st_d.rdata = 32'h0000_0000;
        clk_edge = 1'b0;
        // software clears go first, so a hardware set in this cycle wins
        if (bus.rd && bus.addr == `DIOTH_REG_DATA
            && !st_q.ctrl[`DIOTH_CTL_OUTDIR])
            st_d.valid = 1'b0;
        if (bus.wr && bus.addr == `DIOTH_REG_STATUS)
        begin
            st_d.ovf = st_q.ovf & ~bus.wdata[`DIOTH_ST_OVF];
            st_d.late = st_q.late & ~bus.wdata[`DIOTH_ST_LATE];
            st_d.badmode = st_q.badmode & ~bus.wdata[`DIOTH_ST_BADMODE];
        end
        // sample clock from divider or external pin
        if (st_q.ctrl[`DIOTH_CTL_EXTCLK])
            st_d.sclk = ext_s; // R2
        else if (st_q.cnt >= st_q.div)
        begin
            st_d.cnt = 32'h0000_0000;
            st_d.sclk = ~st_q.sclk; // R2
        end
        else
            st_d.cnt = st_q.cnt + 32'h0000_0001;
        if (st_q.ctrl[`DIOTH_CTL_EN])
        begin
            clk_edge = edge_hit;
            st_d.rdy = 1'b0; // R8
            unique case (mode)
                DIOTH_SAMPCLK:
                    if (clk_edge)
                    begin
                        // single point: previous sample still unread
                        if (st_q.valid && st_q.ctrl[`DIOTH_CTL_SINGLE])
                            st_d.late = 1'b1; // R22
                        st_d.data = din_s; // R1
                        st_d.valid = 1'b1;
                        st_d.count = st_q.count + 32'h0000_0001;
                    end
                DIOTH_ONDEMAND:
                    st_d.data = din_s; // R3
                DIOTH_CHANGE:
                    if (chg != 32'h0000_0000)
                    begin
                        if (st_q.valid)
                            st_d.ovf = 1'b1; // R5
                        st_d.data = din_s;
                        st_d.valid = 1'b1;
                        st_d.count = st_q.count + 32'h0000_0001;
                    end
                DIOTH_HSHAKE:
                    unique case (st_q.hs)
                        DIOTH_IDLE:
                            if (st_q.ctrl[`DIOTH_CTL_OUTDIR])
                            begin
                                if (st_q.valid)
                                begin
                                    st_d.ofull = 1'b0; // R15
                                    st_d.oe = 1'b1; // R20
                                    st_d.hs = DIOTH_WAIT;
                                end
                            end
                            else if (strb_lo && !st_q.valid)
                            begin
                                st_d.data = din_s; // R13
                                st_d.ifull = 1'b1; // R14
                                st_d.valid = 1'b1;
                                st_d.hs = DIOTH_WAIT;
                            end
                        DIOTH_WAIT:
                            if (st_q.ctrl[`DIOTH_CTL_OUTDIR])
                            begin
                                if (ack_lo)
                                begin
                                    st_d.ofull = 1'b1; // R16
                                    st_d.valid = 1'b0;
                                    st_d.hs = DIOTH_DONE;
                                end
                            end
                            else if (!strb_lo)
                                st_d.hs = DIOTH_DONE; // R10
                        DIOTH_DONE:
                            if (!ack_lo && st_q.ctrl[`DIOTH_CTL_OUTDIR])
                                st_d.hs = DIOTH_IDLE;
                            else if (!st_q.ctrl[`DIOTH_CTL_OUTDIR]
                                     && !st_q.valid)
                            begin
                                st_d.ifull = 1'b0; // R10
                                st_d.hs = DIOTH_IDLE;
                            end
                        default:
                            st_d.hs = DIOTH_IDLE;
                    endcase
                DIOTH_BURST:
                begin
                    st_d.rdy = st_q.ctrl[`DIOTH_CTL_OUTDIR]
                             ? st_q.valid : !st_q.valid;
                    st_d.oe = st_q.ctrl[`DIOTH_CTL_OUTDIR]; // R20
                    if (clk_edge && !hold_s && st_q.rdy) // R7 R8
                    begin
                        if (!st_q.ctrl[`DIOTH_CTL_OUTDIR])
                            st_d.data = din_s;
                        st_d.valid = !st_q.ctrl[`DIOTH_CTL_OUTDIR];
                        st_d.rdy = 1'b0;
                        st_d.count = st_q.count + 32'h0000_0001;
                    end
                end
                default:
                    st_d.badmode = 1'b1;
            endcase
            // single point accepts only sample clock or change timing
            if (st_q.ctrl[`DIOTH_CTL_SINGLE] && mode != DIOTH_SAMPCLK
                && mode != DIOTH_CHANGE)
            begin
                st_d.badmode = 1'b1; // R21
                st_d.ctrl[`DIOTH_CTL_EN] = 1'b0;
            end
        end
        else
        begin
            st_d.oe = 1'b0;
            st_d.rdy = 1'b0;
            st_d.hs = DIOTH_IDLE;
        end
        // register reads; reading data consumes the sample when the port is an input (OUTDIR clear)
        if (bus.rd)
        begin
            unique case (bus.addr)
                `DIOTH_REG_CTRL: st_d.rdata = st_q.ctrl;
                `DIOTH_REG_DIV: st_d.rdata = st_q.div;
                `DIOTH_REG_RISE: st_d.rdata = st_q.rise;
                `DIOTH_REG_FALL: st_d.rdata = st_q.fall;
                `DIOTH_REG_STATUS: st_d.rdata = {27'h0000000,
                    st_q.hs != DIOTH_IDLE, st_q.badmode, st_q.late,
                    st_q.valid, st_q.ovf}; // R6
                `DIOTH_REG_DATA:
                    st_d.rdata = (mode == DIOTH_ONDEMAND)
                               ? din_s : st_q.data; // R3
                `DIOTH_REG_OUTDATA: st_d.rdata = st_q.odata;
                `DIOTH_REG_COUNT: st_d.rdata = st_q.count;
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
        // register writes; status clears were taken at the top
        if (bus.wr)
        begin
            unique case (bus.addr)
                `DIOTH_REG_CTRL: st_d.ctrl = bus.wdata;
                `DIOTH_REG_DIV: st_d.div = bus.wdata;
                `DIOTH_REG_RISE: st_d.rise = bus.wdata;
                `DIOTH_REG_FALL: st_d.fall = bus.wdata;
                `DIOTH_REG_OUTDATA:
                begin
                    st_d.odata = bus.wdata & width_mask;
                    st_d.valid = 1'b1;
                end
                `DIOTH_REG_CMD: st_d.count = 32'h0000_0000;
                default: ;
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // idle handshake lines and clear overflow at reset
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            st_q <= '0;
            st_q.div <= `DIOTH_DIV_RST;
            st_q.ofull <= 1'b1; // R23
            st_q.hs_a <= '1;
            st_q.hs_b <= '1;
            st_q.hs <= DIOTH_IDLE;
        end
        else
            st_q <= st_d;
    end

    // outputs: only the top port of the group drives handshake lines
    always_comb
    begin
        input_full_flag = '0;
        output_full_flag = '1;
        dio_out = '0;
        dio_oe = '0;
        input_full_flag[grp] = st_q.ifull; // R17
        output_full_flag[grp] = st_q.ofull; // R17
        dio_out[31:0] = st_q.odata;
        dio_oe[31:0] = {32{st_q.oe}} & width_mask; // R20
    end
    assign transfer_ready = st_q.rdy; // R8
    assign sample_clk_out = st_q.sclk;
    assign rdata = st_q.rdata;

    // ****************************************
    // checks
    // ****************************************
    AST_BURST_STALL: assert property (@(posedge sys_clk) // R8
        disable iff (reset)
        (mode == DIOTH_BURST && hold_s && !bus.wr) |=> $stable(st_q.count))
        else $error("burst moved while hold asserted");
    AST_OVF_STICKY: assert property (@(posedge sys_clk) // R6
        disable iff (reset) (st_q.ovf && !bus.wr) |=> st_q.ovf)
        else $error("overflow lost without clear");
    AST_OFULL_LOW: assert property (@(posedge sys_clk) // R15
        disable iff (reset)
        (st_q.hs == DIOTH_WAIT && st_q.ctrl[`DIOTH_CTL_OUTDIR]
         && mode == DIOTH_HSHAKE) |-> !st_q.ofull)
        else $error("output full high while word presented");
    AST_IFULL_AFTER: assert property (@(posedge sys_clk) // R14
        disable iff (reset)
        (st_q.hs == DIOTH_WAIT && !st_q.ctrl[`DIOTH_CTL_OUTDIR]
         && mode == DIOTH_HSHAKE) |-> st_q.ifull)
        else $error("input full low after word taken");
    AST_SINGLE_MODE: assert property (@(posedge sys_clk) // R21
        disable iff (reset)
        (st_q.ctrl[`DIOTH_CTL_EN] && st_q.ctrl[`DIOTH_CTL_SINGLE]
         && mode != DIOTH_SAMPCLK && mode != DIOTH_CHANGE
         && !bus.wr) |=> st_q.badmode)
        else $error("single point accepted bad timing");
    AST_BURST_MOVE: assert property (@(posedge sys_clk) // R7
        disable iff (reset)
        (mode == DIOTH_BURST && clk_edge && !hold_s && st_q.rdy && !bus.wr)
        |=> st_q.count == $past(st_q.count) + 32'h0000_0001)
        else $error("burst word not moved on permitted edge");
endmodule // dioth_core

// ===== test/dioth_periph.sv
// peripheral model on the far side of the handshake and burst lines
`timescale 1ns/1ps
module dioth_periph
#(
    parameter int NPORT = 4
)
(
    // clock
    input wire logic sys_clk,
    // lines toward the engine
    output logic [8*NPORT-1:0] dio_in,
    output logic [NPORT-1:0] strobe_in,
    output logic [NPORT-1:0] peripheral_acknowledge,
    output logic transfer_hold,
    // lines from the engine
    input wire logic [8*NPORT-1:0] dio_out,
    input wire logic [8*NPORT-1:0] dio_oe,
    input wire logic [NPORT-1:0] input_full_flag,
    input wire logic [NPORT-1:0] output_full_flag
);
    logic [31:0] got_word;
    logic [31:0] got_oe;
    logic hs_ok;
    // idle: strobes and acknowledges high, burst permitted
    initial
    begin
        dio_in = '0;
        strobe_in = '1;
        peripheral_acknowledge = '1;
        transfer_hold = 1'b0;
        hs_ok = 1'b0;
    end
    // drive the data lines just after an edge
    task automatic put_lines(input logic [31:0] w);
        @(posedge sys_clk);
        dio_in[31:0] <= w;
    endtask
    task automatic set_hold(input logic h);
        @(posedge sys_clk);
        transfer_hold <= h;
    endtask
    // all strobes tied as one line, so every port sees the same strobe
    task automatic send_word(input logic [31:0] w, input int top);
        int n;
        n = 0;
        put_lines(w);
        @(posedge sys_clk);
        strobe_in <= '0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end while (input_full_flag[top] !== 1'b1 && n < 50);
        hs_ok = (n < 50);
        @(posedge sys_clk);
        strobe_in <= '1;
        dio_in[31:0] <= ~w; // released lines must not still show the word
    endtask
    // take a presented word and answer with a two-cycle low pulse
    task automatic get_word(input int top);
        int n;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end while (output_full_flag[top] !== 1'b0 && n < 50);
        hs_ok = (n < 50);
        got_word = dio_out[31:0];
        got_oe = dio_oe[31:0];
        @(posedge sys_clk);
        peripheral_acknowledge[top] <= 1'b0;
        repeat (2) @(posedge sys_clk);
        peripheral_acknowledge[top] <= 1'b1;
    endtask
endmodule // dioth_periph

// ===== test/dioth_core_bench.sv
// self-checking bench for the timing and handshake engine
`timescale 1ns/1ps
`include "dioth_cfg.svh"
module dioth_core_bench;
    import dioth_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    dioth_bus_t bus_q = '0;
    logic [31:0] rdata;
    logic [31:0] dio_in, dio_out, dio_oe;
    logic ext_sample_clk = 1'b0;
    logic [3:0] strobe_in, peripheral_acknowledge;
    logic [3:0] input_full_flag, output_full_flag;
    logic transfer_hold, transfer_ready, sample_clk_out;
    int err_total = 0;
    int compares = 0;
    int seed = 62873;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic rd_pend = 1'b0;
    logic [31:0] w;
    // ****************************************
    // clocks, design and peripheral
    // ****************************************
    always #10 sys_clk = ~sys_clk;
    // slow external sample clock, unrelated to the divider
    always
    begin
        repeat (7) @(posedge sys_clk);
        ext_sample_clk <= ~ext_sample_clk;
    end
    dioth_core #(.NPORT(4)) dut (.sys_clk(sys_clk), .reset(reset),
        .bus(bus_q), .rdata(rdata), .dio_in(dio_in), .dio_out(dio_out),
        .dio_oe(dio_oe), .ext_sample_clk(ext_sample_clk),
        .strobe_in(strobe_in),
        .peripheral_acknowledge(peripheral_acknowledge),
        .input_full_flag(input_full_flag),
        .output_full_flag(output_full_flag),
        .transfer_hold(transfer_hold), .transfer_ready(transfer_ready),
        .sample_clk_out(sample_clk_out));
    dioth_periph #(.NPORT(4)) per (.sys_clk(sys_clk), .dio_in(dio_in),
        .strobe_in(strobe_in),
        .peripheral_acknowledge(peripheral_acknowledge),
        .transfer_hold(transfer_hold), .dio_out(dio_out), .dio_oe(dio_oe),
        .input_full_flag(input_full_flag),
        .output_full_flag(output_full_flag));
    // ****************************************
    // bus tasks and comparisons
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_q.wr <= 1'b0;
    endtask
    // the expected word is noted before the strobe goes out
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge sys_clk);
        bus_q <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_q.rd <= 1'b0;
    endtask
    task automatic chk_rd(input logic [31:0] got);
        logic [31:0] e;
        logic [31:0] m;
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        compares++;
        if ((got & m) !== e)
        begin
            err_total++;
            $display("BAD %0t read %h want %h", $time, got & m, e);
        end
    endtask
    task automatic chk_sig(input logic [31:0] got, input logic [31:0] e);
        compares++;
        if (got !== e)
        begin
            err_total++;
            $display("BAD %0t line %h want %h", $time, got, e);
        end
    endtask
    // read data stand only in the cycle after the strobe, seen mid-cycle
    always @(negedge sys_clk)
    begin
        if (rd_pend)
            chk_rd(rdata);
        rd_pend = bus_q.rd;
    end
    task automatic idle_chk;
        @(negedge sys_clk);
        chk_sig({input_full_flag, output_full_flag, transfer_ready,
            sample_clk_out}, 10'h03C);
    endtask
    task automatic give_verdict;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // cut a hang short well past the expected run length
    initial
    begin
        #(20 * 40000);
        err_total++;
        give_verdict();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        idle_chk();
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(`DIOTH_REG_DIV, `DIOTH_DIV_RST, ALL);
        rd(`DIOTH_REG_STATUS, 32'h0, 32'h1F);
        rd(8'h40, 32'h0, ALL);
        wr(`DIOTH_REG_DIV, 32'h1); // fast onboard sample clock
        // on-demand: each read returns the lines at once
        repeat (2)
        begin
            w = $random(seed);
            per.put_lines(w);
            wr(`DIOTH_REG_CTRL, 32'h103);
            repeat (6) @(posedge sys_clk);
            rd(`DIOTH_REG_DATA, w, ALL);
        end
        // change detection on rising edges of line 0 only
        w = $random(seed) & 32'hFFFF_FFFE;
        per.put_lines(w);
        wr(`DIOTH_REG_RISE, 32'h1);
        wr(`DIOTH_REG_FALL, 32'h0);
        wr(`DIOTH_REG_CTRL, 32'h105);
        repeat (8) @(posedge sys_clk);
        per.put_lines(w | 32'h1);
        repeat (8) @(posedge sys_clk);
        rd(`DIOTH_REG_STATUS, 32'h2, 32'h2);
        rd(`DIOTH_REG_DATA, w | 32'h1, ALL);
        per.put_lines(w);
        repeat (8) @(posedge sys_clk);
        rd(`DIOTH_REG_STATUS, 32'h0, 32'h3);
        repeat (2)
        begin
            per.put_lines(w | 32'h1);
            repeat (8) @(posedge sys_clk);
            per.put_lines(w);
            repeat (8) @(posedge sys_clk);
        end
        rd(`DIOTH_REG_STATUS, 32'h1, 32'h1);
        wr(`DIOTH_REG_STATUS, 32'h1);
        rd(`DIOTH_REG_STATUS, 32'h0, 32'h1);
        // consume the last change sample so the handshake can start
        rd(`DIOTH_REG_DATA, w | 32'h1, ALL);
        // strobed input, 32-bit words, top port 3
        wr(`DIOTH_REG_CTRL, 32'hD07);
        repeat (2)
        begin
            w = $random(seed);
            per.send_word(w, 3);
            chk_sig(per.hs_ok, 1);
            @(negedge sys_clk);
            chk_sig(input_full_flag, 4'h8);
            rd(`DIOTH_REG_DATA, w, ALL);
            repeat (6) @(posedge sys_clk);
            chk_sig(input_full_flag, 4'h0);
        end
        // strobed output on the same top port
        wr(`DIOTH_REG_CTRL, 32'hD47);
        repeat (2)
        begin
            w = $random(seed);
            wr(`DIOTH_REG_OUTDATA, w);
            per.get_word(3);
            chk_sig(per.hs_ok, 1);
            chk_sig(per.got_word, w);
            chk_sig(per.got_oe, ALL);
            repeat (8) @(posedge sys_clk);
            chk_sig(output_full_flag, 4'hF);
        end
        // burst held off: no word moves for any clock source or edge
        per.set_hold(1'b1);
        for (int e = 0; e < 4; e++)
        begin
            wr(`DIOTH_REG_CTRL, 32'h9 | (e << 4));
            wr(`DIOTH_REG_CMD, 32'h1);
            repeat (200) @(posedge sys_clk);
            rd(`DIOTH_REG_COUNT, 32'h0, ALL);
        end
        // hold released: one word moves, then ready drops until it is read
        w = $random(seed);
        per.put_lines(w);
        wr(`DIOTH_REG_CTRL, 32'h109);
        wr(`DIOTH_REG_CMD, 32'h1);
        per.set_hold(1'b0);
        repeat (40) @(posedge sys_clk);
        chk_sig(transfer_ready, 0);
        rd(`DIOTH_REG_COUNT, 32'h1, ALL);
        rd(`DIOTH_REG_DATA, w, ALL);
        // single point refuses handshake timing, flags a late read
        wr(`DIOTH_REG_CTRL, 32'h207);
        repeat (4) @(posedge sys_clk);
        rd(`DIOTH_REG_STATUS, 32'h8, 32'h8);
        wr(`DIOTH_REG_CTRL, 32'h201);
        wr(`DIOTH_REG_STATUS, 32'hF);
        rd(`DIOTH_REG_STATUS, 32'h0, 32'h8);
        repeat (40) @(posedge sys_clk);
        rd(`DIOTH_REG_STATUS, 32'h4, 32'h4);
        // second reset in mid-run
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        idle_chk();
        @(posedge sys_clk);
        reset <= 1'b0;
        rd(`DIOTH_REG_STATUS, 32'h0, 32'h7);
        repeat (4) @(posedge sys_clk);
        give_verdict();
    end
endmodule // dioth_core_bench
